// >>> tb/emalm_ext_ctl.sv
`timescale 1ns/1ps
module emalm_ext_ctl (
	input  wire logic       sys_clk,
	input  wire logic       fault_req,
	input  wire logic [3:0] fault_lag,
	input  wire logic       alarm_pin_oe,
	input  wire logic       alarm_pullup_on,
	output logic            alarm_pin
);
	logic [3:0] lag_q = '0;
	logic       pull_q = 1'h0;
	logic       float_q = 1'h0;
	always @(posedge sys_clk) begin
		lag_q <= fault_req ? (lag_q == fault_lag ? lag_q : lag_q + 4'h1) : 4'h0;
		pull_q <= fault_req && lag_q == fault_lag;
		float_q <= !float_q;
	end
	// pull-up only while alarm_pullup_on is set: otherwise an undriven pin wanders instead of holding high
	always_comb alarm_pin = (alarm_pin_oe || pull_q) ? 1'h0 : (alarm_pullup_on ? 1'h1 : float_q);
endmodule : emalm_ext_ctl

// >>> tb/emalm_top_asserts.sv
`timescale 1ns/1ps
module emalm_top_asserts (
	input wire logic       sys_clk,
	input wire logic       reset,
	input wire logic       reg_we,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       track_err,
	input wire logic       config_err,
	input wire logic       temp_above_off,
	input wire logic       alarm_pin_i,
	input wire logic       alarm_pin_oe,
	input wire logic       alarm_pullup_on,
	input wire logic       input_filter_on,
	input wire logic       line_drivers_on,
	input wire logic       supply_control_output
);
	// shadow of the few register bits the properties need
	logic pol_q, sd8_q, sd4_q, latch_q, am8_q;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			{pol_q, sd8_q, sd4_q, latch_q, am8_q} <= '0;
		end else if (reg_we) begin
			if (reg_addr == emalm_pkg::ADDR_ALARM_CFG) begin
				latch_q <= reg_wdata[emalm_pkg::BIT_LATCH_MODE];
				pol_q   <= reg_wdata[emalm_pkg::BIT_POLARITY];
				sd8_q   <= reg_wdata[0];
			end
			if (reg_addr == emalm_pkg::ADDR_SMASK_LO) begin
				sd4_q <= reg_wdata[emalm_pkg::EV_INDEX_SYS];
			end
			if (reg_addr == emalm_pkg::ADDR_AMASK_HI) begin
				am8_q <= reg_wdata[0];
			end
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// sync chain plus blanking is at most eight cycles
	sequence s_ext_low;
		(!alarm_pin_i && !alarm_pin_oe) [*8];
	endsequence
	property p_sys_err;
		!pol_q && sd4_q && line_drivers_on ##0 s_ext_low |=> !line_drivers_on;
	endproperty
	property p_alarm;
		am8_q && track_err ##1 line_drivers_on |-> alarm_pin_oe == !$past(pol_q);
	endproperty
	property p_cfg;
		config_err |=> !line_drivers_on;
	endproperty
	property p_temp;
		temp_above_off [*6] |=> !line_drivers_on;
	endproperty
	property p_sd;
		sd8_q && track_err |=> !line_drivers_on;
	endproperty
	property p_latch;
		latch_q && !line_drivers_on |=> !line_drivers_on;
	endproperty
	property p_supply;
		!line_drivers_on [*2] |-> supply_control_output;
	endproperty
	property p_tri;
		!line_drivers_on [*2] |-> !alarm_pin_oe;
	endproperty
	property p_pullup;
		reg_we && reg_addr == emalm_pkg::ADDR_ALARM_CFG |-> ##2
			alarm_pullup_on == $past(reg_wdata[emalm_pkg::BIT_PULLUP], 2);
	endproperty
	property p_filter;
		reg_we && reg_addr == emalm_pkg::ADDR_FILTER |-> ##2
			input_filter_on == $past(reg_wdata[emalm_pkg::BIT_FILTER_EN], 2);
	endproperty
	a_sys_err: assert property (p_sys_err) else $error("external fault did not shut down");
	a_alarm: assert property (p_alarm) else $error("alarm pin level wrong for event");
	a_cfg: assert property (p_cfg) else $error("config error kept drivers on");
	a_temp: assert property (p_temp) else $error("overheat kept drivers on");
	a_sd: assert property (p_sd) else $error("masked event kept drivers on");
	a_latch: assert property (p_latch) else $error("latched shutdown ended");
	a_supply: assert property (p_supply) else $error("supply range not switched");
	a_tri: assert property (p_tri) else $error("alarm pin driven in shutdown");
	a_pullup: assert property (p_pullup) else $error("pull-up does not follow bit");
	a_filter: assert property (p_filter) else $error("filter does not follow bit");
endmodule : emalm_top_asserts

bind emalm_top emalm_top_asserts u_emalm_top_asserts (.sys_clk, .reset, .reg_we, .reg_addr, .reg_wdata,
	.track_err, .config_err, .temp_above_off, .alarm_pin_i, .alarm_pin_oe, .alarm_pullup_on,
	.input_filter_on, .line_drivers_on, .supply_control_output);

// >>> tb/emalm_top_tb_top.sv
`timescale 1ns/1ps
module emalm_top_tb_top;
	localparam int STEP = 10;
	logic       sys_clk = 1'h0;
	logic       reset = 1'h1;
	logic       reg_we = 1'h0;
	logic [7:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0;
	logic [9:0] ev = '0;
	logic       period_tick = 1'h0;
	logic       zero_pulse = 1'h0;
	logic       direction = 1'h0;
	logic       test_mode = 1'h0;
	logic [2:0] temp = '0;
	logic       fault_req = 1'h0;
	logic       alarm_pin, alarm_pin_o, alarm_pin_oe, alarm_pullup_on, input_filter_on;
	logic       line_drivers_on, supply_control_output, test_point_one;
	logic [7:0] reg_rdata;
	logic [9:0] log_event;
	int         err_count = 0;
	int         checks_done = 0;
	int         evl [7] = '{0, 1, 2, 3, 4, 7, 8};
	logic [23:0] tbl [5] = '{24'h18_ff73, 24'h24_ff3f, 24'h23_a5a5, 24'h40_ff00, 24'h1a_ff73};

	always #2 sys_clk = !sys_clk;

	emalm_top #(.HOLD_STEP_CYCLES(STEP)) u_emalm_top (.sys_clk, .reset, .reg_we, .reg_addr, .reg_wdata,
		.reg_rdata, .track_err(ev[8]), .loss_track_err(ev[7]), .config_err(ev[6]), .index_ungated(ev[4]),
		.ctl_max_err(ev[3]), .ctl_min_err(ev[2]), .clip_err(ev[1]), .los_err(ev[0]), .period_tick,
		.zero_pulse, .direction, .test_mode, .temp_above_warn(temp[0]), .temp_below_hyst(temp[1]),
		.temp_above_off(temp[2]), .alarm_pin_i(alarm_pin), .alarm_pin_o, .alarm_pin_oe, .alarm_pullup_on,
		.input_filter_on, .line_drivers_on, .supply_control_output, .log_event, .test_point_one);
	emalm_ext_ctl u_emalm_ext_ctl (.sys_clk, .fault_req, .fault_lag(4'h5), .alarm_pin_oe, .alarm_pullup_on,
		.alarm_pin);

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc
	task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic oe(input logic e);
		chk("alarm_pin_oe", 10'(e), 10'(alarm_pin_oe));
	endtask : oe
	task automatic drv(input logic e);
		chk("line_drivers_on", 10'(e), 10'(line_drivers_on));
	endtask : drv
	// a lead cycle keeps the strobe from being dropped and raised in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc(1);
		reg_we = 1'h1;
		reg_addr = a;
		reg_wdata = d;
		cyc(1);
		reg_we = 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		cyc(2);
		chk("reg_rdata", 10'(exp), 10'(reg_rdata));
	endtask : rd
	task automatic zp(input int n);
		zero_pulse = 1'h1;
		cyc(1);
		zero_pulse = 1'h0;
		repeat (n) begin
			cyc(1);
			period_tick = 1'h1;
			cyc(1);
			period_tick = 1'h0;
		end
		cyc(2);
	endtask : zp
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize

	initial begin
		cyc(5000);
		err_count++;
		summarize();
	end

	initial begin
		cyc(20);
		reset = 1'h0;
		rd(8'h03, 8'h80);
		rd(8'h1A, 8'h00);
		chk("input_filter_on", 10'h001, 10'(input_filter_on));
		wr(8'h03, 8'h00);
		cyc(1);
		chk("input_filter_on", 10'h000, 10'(input_filter_on));
		foreach (tbl[i]) begin
			wr(tbl[i][23:16], tbl[i][15:8]);
			rd(tbl[i][23:16], tbl[i][7:0]);
		end
		$display("registers done");
		wr(8'h1A, 8'h20);
		wr(8'h17, 8'hFF);
		wr(8'h18, 8'h03);
		cyc(1);
		chk("alarm_pullup_on", 10'h001, 10'(alarm_pullup_on));
		foreach (evl[i]) begin
			ev[evl[i]] = 1'h1;
			cyc(2);
			oe(1'h1);
			ev = '0;
			cyc(2);
			oe(1'h0);
		end
		wr(8'h17, 8'h00);
		wr(8'h18, 8'h00);
		ev = 10'h19F;
		cyc(3);
		oe(1'h0);
		drv(1'h1);
		wr(8'h1A, 8'h30);
		cyc(2);
		oe(1'h1);
		wr(8'h17, 8'h01);
		cyc(2);
		oe(1'h0);
		// high-active polarity is the only way a config fault shows on the pin
		ev = 10'h040;
		cyc(3);
		drv(1'h0);
		chk("supply_control_output", 10'h001, 10'(supply_control_output));
		oe(1'h0);
		ev = '0;
		cyc(3);
		drv(1'h1);
		$display("alarm events done");
		wr(8'h1A, 8'h20);
		wr(8'h17, 8'h00);
		wr(8'h18, 8'h21);
		ev[8] = 1'h1;
		cyc(2);
		ev = '0;
		cyc(2 * STEP - 2);
		oe(1'h1);
		cyc(7);
		oe(1'h0);
		$display("hold time done");
		wr(8'h18, 8'h02);
		wr(8'h1C, 8'h02);
		wr(8'h23, 8'h03);
		wr(8'h24, 8'h00);
		test_mode = 1'h1;
		zp(4);
		chk("test_point_one", 10'h000, 10'(test_point_one));
		zp(5);
		oe(1'h0);
		chk("test_point_one", 10'h001, 10'(test_point_one));
		zp(4);
		oe(1'h1);
		chk("log_event", 10'h200, log_event);
		zp(2);
		oe(1'h0);
		direction = 1'h1;
		cyc(1);
		zp(3);
		oe(1'h0);
		zp(0);
		oe(1'h1);
		$display("line count done");
		wr(8'h18, 8'h00);
		wr(8'h17, 8'h20);
		temp = 3'h1;
		cyc(6);
		oe(1'h1);
		temp = 3'h0;
		cyc(6);
		oe(1'h1);
		temp = 3'h2;
		cyc(6);
		oe(1'h0);
		temp = 3'h4;
		cyc(6);
		drv(1'h0);
		temp = 3'h0;
		cyc(6);
		drv(1'h1);
		wr(8'h1A, 8'h21);
		ev[8] = 1'h1;
		cyc(2);
		drv(1'h0);
		ev = '0;
		cyc(2);
		drv(1'h1);
		wr(8'h1A, 8'h61);
		ev[8] = 1'h1;
		cyc(2);
		ev = '0;
		cyc(4);
		drv(1'h0);
		reset = 1'h1;
		cyc(2);
		reset = 1'h0;
		cyc(2);
		drv(1'h1);
		chk("alarm_pullup_on", 10'h000, 10'(alarm_pullup_on));
		chk("alarm_pin_o", 10'h000, 10'(alarm_pin_o));
		$display("shutdown done");
		wr(8'h1A, 8'h20);
		wr(8'h19, 8'h10);
		wr(8'h1B, 8'h10);
		fault_req = 1'h1;
		cyc(20);
		drv(1'h0);
		chk("log_event", 10'h010, log_event);
		fault_req = 1'h0;
		cyc(10);
		drv(1'h1);
		$display("system error done");
		summarize();
	end
endmodule : emalm_top_tb_top

// >>> verilog/emalm_pkg.sv
package emalm_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_FILTER      = 8'h03;
	localparam logic [7:0] ADDR_AMASK_LO    = 8'h17;
	localparam logic [7:0] ADDR_AMASK_HI    = 8'h18;
	localparam logic [7:0] ADDR_SMASK_LO    = 8'h19;
	localparam logic [7:0] ADDR_ALARM_CFG   = 8'h1A;
	localparam logic [7:0] ADDR_LMASK_LO    = 8'h1B;
	localparam logic [7:0] ADDR_LMASK_HI    = 8'h1C;
	localparam logic [7:0] ADDR_LREF_LO     = 8'h23;
	localparam logic [7:0] ADDR_LREF_HI     = 8'h24;
	// field positions
	localparam int BIT_FILTER_EN     = 7;
	localparam int BIT_HOLD_LSB      = 4;
	localparam int BIT_POLARITY      = 4;
	localparam int BIT_PULLUP        = 5;
	localparam int BIT_LATCH_MODE    = 6;
	// event vector bit positions
	localparam int EV_LINE_COUNT  = 9;
	localparam int EV_TRACK       = 8;
	localparam int EV_LOSS_TRACK  = 7;
	localparam int EV_CONFIG      = 6;
	localparam int EV_TEMP_WARN   = 5;
	localparam int EV_INDEX_SYS   = 4;
	localparam int EV_CTL_MAX     = 3;
	localparam int EV_CTL_MIN     = 2;
	localparam int EV_CLIP        = 1;
	localparam int EV_LOS         = 0;
	localparam int NUM_EVENTS     = 10;
	// reset values
	localparam logic        RST_FILTER_EN = 1'b1;
	localparam logic [9:0]  RST_MASK      = 10'h000;
	localparam logic [2:0]  RST_HOLD      = 3'h0;
	localparam logic [13:0] RST_LREF      = 14'h0000;
	// timing
	localparam int CLK_MHZ          = 250;
	localparam int HOLD_STEP_US     = 12500;
	localparam int HOLD_STEP_CYCLES = HOLD_STEP_US * CLK_MHZ;
	localparam int SENSE_BLANK      = 4;
endpackage : emalm_pkg

// >>> verilog/emalm_top.sv
// What this block does
// RULE1: one bit enables input filter, default on
// RULE2: three masks gate each event's actions (code never logs events 8..6, whatever the log mask holds)
// RULE3: alarm pin open-drain, optional pull-up enable
// RULE4: polarity bit selects low-on-error or low-without-error
// RULE5: external low on released pin is system error (code senses it only with the polarity bit clear, low-on-error)
// RULE6: hold time is code times 12.5 ms
// RULE7: alarm mask bits 9..5 event assignment
// RULE8: bits 4..0 index, supply limits, clip, loss
// RULE9: set mask bit lets event drive pin
// RULE10: report config errors using high-active polarity
// RULE11: count periods between zero pulses, compare reference
// RULE12: direction reversal pauses check until next zero
// RULE13: expected period count is code plus one
// RULE14: test output flags first completed comparison
// RULE15: temperature warning with hysteresis clearing
// RULE16: shutdown threshold forces driver shutdown
// RULE17: shutdown sets 5mA supply range, tristates pins
// RULE18: overheating or config error always shuts down
// RULE19: latch mode keeps shutdown until power cycle
// RULE20: shutdown mask bit makes event shut down
// RULE21: alarm held for selected time after error
`timescale 1ns/1ps

module emalm_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] ff1_q;
	logic [W-1:0] ff2_q;
	logic [W-1:0] ff3_q;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ff1_q <= '0;
			ff2_q <= '0;
			ff3_q <= '0;
		end else begin
			ff1_q <= async_in;
			ff2_q <= ff1_q;
			ff3_q <= ff2_q;
		end
	end

	// a bit only moves once two stages agree, per bit
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sync_out <= '0;
		end else begin
			sync_out <= (ff2_q & ff3_q) | (sync_out & (ff2_q | ff3_q));
		end
	end
endmodule : emalm_sync

module emalm_top #(
	parameter int HOLD_STEP_CYCLES = emalm_pkg::HOLD_STEP_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// byte register port
	input  wire logic        reg_we,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// error sources inside the interpolator
	input  wire logic        track_err,
	input  wire logic        loss_track_err,
	input  wire logic        config_err,
	input  wire logic        index_ungated,
	input  wire logic        ctl_max_err,
	input  wire logic        ctl_min_err,
	input  wire logic        clip_err,
	input  wire logic        los_err,
	input  wire logic        period_tick,
	input  wire logic        zero_pulse,
	input  wire logic        direction,
	input  wire logic        test_mode,
	// temperature comparators (analog side)
	input  wire logic        temp_above_warn,
	input  wire logic        temp_below_hyst,
	input  wire logic        temp_above_off,
	// alarm pin
	input  wire logic        alarm_pin_i,
	output logic             alarm_pin_o,
	output logic             alarm_pin_oe,
	output logic             alarm_pullup_on,
	// actions
	output logic             input_filter_on,
	output logic             line_drivers_on,
	output logic             supply_control_output,
	output logic [9:0]       log_event,
	output logic             test_point_one
);
	logic        input_filter_enable_q;
	logic [9:0]  alarm_event_mask_q;
	logic [9:0]  shutdown_event_mask_q;
	logic [9:0]  log_event_mask_q;
	logic [2:0]  alarm_min_hold_time_q;
	logic        alarm_polarity_q;
	logic        alarm_pullup_enable_q;
	logic        shutdown_latch_mode_q;
	logic [13:0] line_count_reference_q;

	logic [3:0]  pin_sync;
	logic        pin_low;
	logic        temp_warn_in;
	logic        temp_clr_in;
	logic        temp_off_in;

	emalm_sync #(.W(4)) u_sync (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in ({~alarm_pin_i, temp_above_warn, temp_below_hyst, temp_above_off}),
		.sync_out (pin_sync)
	);
	assign pin_low      = pin_sync[3];
	assign temp_warn_in = pin_sync[2];
	assign temp_clr_in  = pin_sync[1];
	assign temp_off_in  = pin_sync[0];

	// register writes
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			input_filter_enable_q  <= emalm_pkg::RST_FILTER_EN;
			alarm_event_mask_q     <= emalm_pkg::RST_MASK;
			shutdown_event_mask_q  <= emalm_pkg::RST_MASK;
			log_event_mask_q       <= emalm_pkg::RST_MASK;
			alarm_min_hold_time_q  <= emalm_pkg::RST_HOLD;
			alarm_polarity_q       <= 1'b0;
			alarm_pullup_enable_q  <= 1'b0;
			shutdown_latch_mode_q  <= 1'b0;
			line_count_reference_q <= emalm_pkg::RST_LREF;
		end else if (reg_we) begin
			if (reg_addr == emalm_pkg::ADDR_FILTER) begin
				input_filter_enable_q <= reg_wdata[emalm_pkg::BIT_FILTER_EN]; // [RULE1]
			end else if (reg_addr == emalm_pkg::ADDR_AMASK_LO) begin
				alarm_event_mask_q[7:0] <= reg_wdata;
			end else if (reg_addr == emalm_pkg::ADDR_AMASK_HI) begin
				alarm_event_mask_q[9:8] <= reg_wdata[1:0];
				alarm_min_hold_time_q   <= reg_wdata[emalm_pkg::BIT_HOLD_LSB +: 3];
			end else if (reg_addr == emalm_pkg::ADDR_SMASK_LO) begin
				shutdown_event_mask_q[7:0] <= reg_wdata;
			end else if (reg_addr == emalm_pkg::ADDR_ALARM_CFG) begin
				shutdown_event_mask_q[9:8] <= reg_wdata[1:0];
				alarm_polarity_q           <= reg_wdata[emalm_pkg::BIT_POLARITY];
				alarm_pullup_enable_q      <= reg_wdata[emalm_pkg::BIT_PULLUP];
				shutdown_latch_mode_q      <= reg_wdata[emalm_pkg::BIT_LATCH_MODE];
			end else if (reg_addr == emalm_pkg::ADDR_LMASK_LO) begin
				log_event_mask_q[7:0] <= reg_wdata;
			end else if (reg_addr == emalm_pkg::ADDR_LMASK_HI) begin
				log_event_mask_q[9:8] <= reg_wdata[1:0];
			end else if (reg_addr == emalm_pkg::ADDR_LREF_LO) begin
				line_count_reference_q[7:0] <= reg_wdata;
			end else if (reg_addr == emalm_pkg::ADDR_LREF_HI) begin
				line_count_reference_q[13:8] <= reg_wdata[5:0];
			end
		end
	end

	// register reads, registered; unmapped and reserved bits read zero
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_addr == emalm_pkg::ADDR_FILTER) begin
			reg_rdata <= {input_filter_enable_q, 7'h00};
		end else if (reg_addr == emalm_pkg::ADDR_AMASK_LO) begin
			reg_rdata <= alarm_event_mask_q[7:0];
		end else if (reg_addr == emalm_pkg::ADDR_AMASK_HI) begin
			reg_rdata <= {1'b0, alarm_min_hold_time_q, 2'b00, alarm_event_mask_q[9:8]};
		end else if (reg_addr == emalm_pkg::ADDR_SMASK_LO) begin
			reg_rdata <= shutdown_event_mask_q[7:0];
		end else if (reg_addr == emalm_pkg::ADDR_ALARM_CFG) begin
			reg_rdata <= {1'b0, shutdown_latch_mode_q, alarm_pullup_enable_q, alarm_polarity_q,
				2'b00, shutdown_event_mask_q[9:8]};
		end else if (reg_addr == emalm_pkg::ADDR_LMASK_LO) begin
			reg_rdata <= log_event_mask_q[7:0];
		end else if (reg_addr == emalm_pkg::ADDR_LMASK_HI) begin
			reg_rdata <= {6'h00, log_event_mask_q[9:8]};
		end else if (reg_addr == emalm_pkg::ADDR_LREF_LO) begin
			reg_rdata <= line_count_reference_q[7:0];
		end else if (reg_addr == emalm_pkg::ADDR_LREF_HI) begin
			reg_rdata <= {2'b00, line_count_reference_q[13:8]};
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// line count check
	logic [14:0] period_cnt_q;
	logic        lc_armed_q;
	logic        lc_err_q;
	logic        lc_first_done_q;
	logic        dir_q;
	logic        dir_flip;
	logic [14:0] expected_cnt;

	assign dir_flip     = direction != dir_q;
	assign expected_cnt = {1'b0, line_count_reference_q} + 15'h0001; // [RULE13]

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dir_q <= 1'b0;
		end else begin
			dir_q <= direction;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			period_cnt_q    <= 15'h0000;
			lc_armed_q      <= 1'b0;
			lc_err_q        <= 1'b0;
			lc_first_done_q <= 1'b0;
		end else if (dir_flip) begin
			lc_armed_q   <= 1'b0; // [RULE12]
			period_cnt_q <= 15'h0000;
		end else if (zero_pulse) begin
			if (lc_armed_q) begin
				lc_err_q        <= period_cnt_q != expected_cnt; // [RULE11]
				lc_first_done_q <= 1'b1;
			end
			lc_armed_q   <= 1'b1; // [RULE12]
			period_cnt_q <= {14'h0000, period_tick};
		end else if (period_tick && period_cnt_q != 15'h7FFF) begin
			// saturate so a missing zero pulse never wraps back to a match
			period_cnt_q <= period_cnt_q + 15'h0001;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			test_point_one <= 1'b0;
		end else begin
			test_point_one <= test_mode & lc_first_done_q; // [RULE14]
		end
	end

	// temperature warning with hysteresis
	logic temp_warn_q;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			temp_warn_q <= 1'b0;
		end else if (temp_warn_in) begin
			temp_warn_q <= 1'b1; // [RULE15]
		end else if (temp_clr_in) begin
			temp_warn_q <= 1'b0; // [RULE15]
		end
	end

	// system error sensing; blank a few cycles after release so our own low is not seen
	logic [emalm_pkg::SENSE_BLANK-1:0] released_q;
	logic                              sys_err;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			released_q <= '0;
		end else begin
			released_q <= {released_q[emalm_pkg::SENSE_BLANK-2:0], ~alarm_pin_oe};
		end
	end
	assign sys_err = ~alarm_polarity_q & (&released_q) & ~alarm_pin_oe & pin_low; // [RULE5]

	logic [9:0] events_alarm;
	logic [9:0] events_other;
	// [RULE7] [RULE8]
	assign events_alarm = {lc_err_q, track_err, loss_track_err, config_err, temp_warn_q,
		index_ungated, ctl_max_err, ctl_min_err, clip_err, los_err};
	assign events_other = {lc_err_q, track_err, loss_track_err, config_err, temp_warn_q,
		sys_err, ctl_max_err, ctl_min_err, clip_err, los_err};

	// driver shutdown
	logic shut_cause;
	logic shut_q;
	assign shut_cause = (|(events_other & shutdown_event_mask_q)) // [RULE2] [RULE20]
		| temp_off_in | config_err; // [RULE16] [RULE18]

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			shut_q <= 1'b0;
		end else begin
			shut_q <= shut_cause | (shutdown_latch_mode_q & shut_q); // [RULE19]
		end
	end

	// minimum indication time
	logic        alarm_raw;
	logic [2:0]  hold_steps_q;
	logic [31:0] hold_tick_q;
	logic        alarm_active;
	assign alarm_raw    = |(events_alarm & alarm_event_mask_q); // [RULE2] [RULE9]
	assign alarm_active = alarm_raw | (hold_steps_q != 3'h0);

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			hold_steps_q <= 3'h0;
			hold_tick_q  <= 32'h0000_0000;
		end else if (alarm_raw) begin
			hold_steps_q <= alarm_min_hold_time_q; // [RULE6]
			hold_tick_q  <= 32'h0000_0000;
		end else if (hold_steps_q != 3'h0) begin
			if (hold_tick_q == 32'(HOLD_STEP_CYCLES - 1)) begin
				hold_tick_q  <= 32'h0000_0000;
				hold_steps_q <= hold_steps_q - 3'h1; // [RULE21]
			end else begin
				hold_tick_q <= hold_tick_q + 32'h0000_0001;
			end
		end
	end

	// outputs
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			alarm_pin_o           <= 1'b0;
			alarm_pin_oe          <= 1'b0;
			alarm_pullup_on       <= 1'b0;
			input_filter_on       <= emalm_pkg::RST_FILTER_EN;
			line_drivers_on       <= 1'b0;
			supply_control_output <= 1'b0;
			log_event             <= 10'h000;
		end else begin
			alarm_pin_o           <= 1'b0; // [RULE3]
			alarm_pin_oe          <= ~shut_cause & ~shut_q
				& (alarm_polarity_q ? ~alarm_active : alarm_active); // [RULE4] [RULE17]
			alarm_pullup_on       <= alarm_pullup_enable_q; // [RULE3]
			input_filter_on       <= input_filter_enable_q; // [RULE1]
			line_drivers_on       <= ~shut_cause & ~shut_q; // [RULE17]
			supply_control_output <= shut_cause | shut_q; // [RULE17]
			log_event             <= events_other & log_event_mask_q & 10'h23F; // [RULE2]
		end
	end
endmodule : emalm_top
